// ===== src/pcs_latency_ctrl.sv
// PCS control for fixed latency, SDI configuration and loopback selection.
// Assumes an Avalon-MM master with waitrequest and a word aligner that pulses on sync.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "pcs_lat_defs.svh"
module pcs_latency_ctrl #(
  parameter int DW = 10
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM register slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Word aligner side of the receiver.
  input wire logic [DW-1:0] rx_word,
  input wire logic rx_word_valid,
  output logic rx_word_ready,
  input wire logic aligner_sync,
  input wire logic [4:0] aligner_slip,
  output logic aligner_slip_req,
  output logic [4:0] rx_slip_count,
  // Fabric receive and transmit.
  output logic [DW-1:0] fab_rx_data,
  output logic fab_rx_valid,
  input wire logic fab_rx_ready,
  input wire logic [DW-1:0] fab_tx_data,
  input wire logic fab_tx_valid,
  input wire logic rx_slip_req,
  // PIPE controls.
  input wire logic detect_loopback,
  input wire logic [1:0] power_state,
  // Serializer side and configuration outputs.
  output logic [DW-1:0] ser_tx_data,
  output logic ser_tx_valid,
  output logic serial_lpbk_en,
  output logic rev_serial_lpbk_en,
  output logic rev_par_lpbk_en,
  output logic phase_freq_detector_fb,
  output logic fb_from_coreclk,
  output logic bonded_x4,
  output logic fabric_width_20
);
  if (DW != 8 && DW != 10) begin : g_bad_width
    $error("word width must be 8 or 10");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus.

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  pcs_lat_pkg::bus_state_t bus_reg, bus_next;
  pcs_lat_pkg::ctrl_t ctrl_reg, ctrl_next;
  logic [4:0] tx_slip_reg, tx_slip_next;
  logic [4:0] rx_slip_reg, rx_slip_next;
  logic slip_rej_reg, slip_rej_next;
  logic cfg_err_reg, cfg_err_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] wmerged, status_word;
  logic wr_ctrl, wr_slip, wr_status;
  logic [4:0] slip_wr_val;

  assign status_word = {28'h000_0000, fabric_width_20, slip_rej_reg, rev_par_lpbk_en,
                        cfg_err_reg};

  // Waitrequest stays high until the cycle after a request is seen; writes land then.
  always_comb begin
    bus_next = bus_reg;
    rdata_next = rdata_reg;
    wr_ctrl = 1'b0;
    wr_slip = 1'b0;
    wr_status = 1'b0;
    wmerged = 32'h0000_0000;
    case (bus_reg)
      pcs_lat_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_next = pcs_lat_pkg::BUS_ANS;
          if (avs_address == `OFS_CTRL) begin
            rdata_next = {20'h0_0000, ctrl_reg};
          end else if (avs_address == `OFS_TX_SLIP) begin
            rdata_next = {27'h000_0000, tx_slip_reg};
          end else if (avs_address == `OFS_RX_SLIP) begin
            rdata_next = {27'h000_0000, rx_slip_reg};
          end else if (avs_address == `OFS_STATUS) begin
            rdata_next = status_word;
          end else begin
            rdata_next = 32'h0000_0000;
          end
        end
      end
      pcs_lat_pkg::BUS_ANS: begin
        bus_next = pcs_lat_pkg::BUS_IDLE;
        if (avs_write) begin
          if (avs_address == `OFS_CTRL) begin
            wr_ctrl = 1'b1;
            wmerged = be_merge({20'h0_0000, ctrl_reg}, avs_writedata, avs_byteenable);
          end else if (avs_address == `OFS_TX_SLIP) begin
            wr_slip = 1'b1;
            wmerged = be_merge({27'h000_0000, tx_slip_reg}, avs_writedata, avs_byteenable);
          end else if (avs_address == `OFS_STATUS) begin
            wr_status = avs_byteenable[0];
            wmerged = avs_writedata;
          end
        end
      end
      default: begin
        bus_next = pcs_lat_pkg::BUS_IDLE;
      end
    endcase
  end

  assign slip_wr_val = wmerged[4:0];

  // A slip beyond nine bits cannot be served; the old value stays and a flag is raised.
  always_comb begin
    ctrl_next = ctrl_reg;
    tx_slip_next = tx_slip_reg;
    slip_rej_next = slip_rej_reg;
    if (wr_ctrl) begin
      ctrl_next = pcs_lat_pkg::ctrl_t'(wmerged[`CTRL_W-1:0]);
    end
    if (wr_status && wmerged[`ST_SLIP_REJ]) begin
      slip_rej_next = 1'b0;
    end
    if (wr_slip) begin
      if (slip_wr_val <= `SLIP_MAX) begin
        tx_slip_next = slip_wr_val;
      end else begin
        slip_rej_next = 1'b1;
      end
    end
  end

  // The count changes only on a sync pulse, so a read between syncs is stable.
  always_comb begin
    rx_slip_next = rx_slip_reg;
    if (aligner_sync && ctrl_reg.manual_align) begin
      rx_slip_next = aligner_slip;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_reg <= pcs_lat_pkg::BUS_IDLE;
      rdata_reg <= 32'h0000_0000;
      ctrl_reg <= pcs_lat_pkg::ctrl_t'(`CTRL_RESET);
      tx_slip_reg <= 5'h00;
      rx_slip_reg <= 5'h00;
      slip_rej_reg <= 1'b0;
    end else begin
      bus_reg <= bus_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
      tx_slip_reg <= tx_slip_next;
      rx_slip_reg <= rx_slip_next;
      slip_rej_reg <= slip_rej_next;
    end
  end

  assign avs_waitrequest = (bus_reg != pcs_lat_pkg::BUS_ANS);
  assign avs_readdata = rdata_reg;
  assign rx_slip_count = rx_slip_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode and loopback decode.

  logic bonded_next, pfd_next, coreclk_next, w20_next;
  logic ser_lb_next, rser_lb_next, rpar_next, slipreq_next;
  logic bonded_reg, pfd_reg, coreclk_reg, w20_reg;
  logic ser_lb_reg, rser_lb_reg, rpar_reg, slipreq_reg;
  logic is_fixed, is_sdi, is_pipe;

  assign is_fixed = (ctrl_reg.mode == pcs_lat_pkg::MODE_FIXED);
  assign is_sdi = (ctrl_reg.mode == pcs_lat_pkg::MODE_SDI);
  assign is_pipe = (ctrl_reg.mode == pcs_lat_pkg::MODE_PIPE);

  // Illegal combinations are forced to a safe setting, not obeyed; serial loopback in PIPE and reverse serial in XAUI are not reported.
  always_comb begin
    bonded_next = ctrl_reg.bonded && !is_sdi;
    coreclk_next = bonded_next;
    pfd_next = is_fixed && ctrl_reg.pfd_fb && ctrl_reg.refclk_eq;
    w20_next = ctrl_reg.byte_ser || (is_sdi && ctrl_reg.sdi_3g);
    ser_lb_next = (ctrl_reg.lpbk_sel == `LPBK_SERIAL) && !is_pipe;
    rser_lb_next = (ctrl_reg.lpbk_sel == `LPBK_REV_SER)
                   && (ctrl_reg.mode != pcs_lat_pkg::MODE_XAUI);
    rpar_next = is_pipe && (ctrl_reg.lpbk_sel == `LPBK_REV_PAR)
                && detect_loopback && (power_state == `PWR_P0);
    slipreq_next = rx_slip_req && !is_sdi;
    cfg_err_next = (is_sdi && ctrl_reg.bonded)
                   || (is_sdi && ctrl_reg.sdi_3g && !ctrl_reg.byte_ser)
                   || (ctrl_reg.pfd_fb && !ctrl_reg.refclk_eq)
                   || (ctrl_reg.lpbk_sel == `LPBK_REV_PAR && !is_pipe);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bonded_reg <= 1'b0;
      pfd_reg <= 1'b0;
      coreclk_reg <= 1'b0;
      w20_reg <= 1'b0;
      ser_lb_reg <= 1'b0;
      rser_lb_reg <= 1'b0;
      rpar_reg <= 1'b0;
      slipreq_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
    end else begin
      bonded_reg <= bonded_next;
      pfd_reg <= pfd_next;
      coreclk_reg <= coreclk_next;
      w20_reg <= w20_next;
      ser_lb_reg <= ser_lb_next;
      rser_lb_reg <= rser_lb_next;
      rpar_reg <= rpar_next;
      slipreq_reg <= slipreq_next;
      cfg_err_reg <= cfg_err_next;
    end
  end

  assign bonded_x4 = bonded_reg;
  assign phase_freq_detector_fb = pfd_reg;
  assign fb_from_coreclk = coreclk_reg;
  assign fabric_width_20 = w20_reg;
  assign serial_lpbk_en = ser_lb_reg;
  assign rev_serial_lpbk_en = rser_lb_reg;
  assign rev_par_lpbk_en = rpar_reg;
  assign aligner_slip_req = slipreq_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Datapath. The channel adds no scrambling or CRC: words pass bit for bit.

  logic [DW-1:0] lb_word_reg, lb_word_next, tx_stage_reg, tx_stage_next, tx_sel;
  logic lb_valid_reg, lb_valid_next, tx_stage_v_reg, tx_stage_v_next, tx_sel_v;
  logic rx_take;

  // The receive stage is a two-entry buffer: one register while the fabric keeps taking words, more when it stalls.
  rx_word_buffer #(.DW(DW)) u_rx_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_data(rx_word),
    .in_valid(rx_word_valid),
    .in_ready(rx_word_ready),
    .out_data(fab_rx_data),
    .out_valid(fab_rx_valid),
    .out_ready(fab_rx_ready)
  );

  assign rx_take = rx_word_valid && rx_word_ready;

  always_comb begin
    lb_word_next = rx_take ? rx_word : lb_word_reg;
    lb_valid_next = rx_take;
    tx_stage_next = fab_tx_data;
    tx_stage_v_next = fab_tx_valid;
    if (rpar_reg) begin
      tx_sel = lb_word_reg;
      tx_sel_v = lb_valid_reg;
    end else if (ctrl_reg.tx_fifo_reg || !is_fixed) begin
      tx_sel = tx_stage_reg;
      tx_sel_v = tx_stage_v_reg;
    end else begin
      tx_sel = fab_tx_data;
      tx_sel_v = fab_tx_valid;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lb_word_reg <= '0;
      lb_valid_reg <= 1'b0;
      tx_stage_reg <= '0;
      tx_stage_v_reg <= 1'b0;
    end else begin
      lb_word_reg <= lb_word_next;
      lb_valid_reg <= lb_valid_next;
      tx_stage_reg <= tx_stage_next;
      tx_stage_v_reg <= tx_stage_v_next;
    end
  end

  tx_bit_slip #(.DW(DW)) u_tx_slip (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_data(tx_sel),
    .in_valid(tx_sel_v),
    .slip(tx_slip_reg),
    .out_data(ser_tx_data),
    .out_valid(ser_tx_valid)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_rx_slip_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !aligner_sync |=> $stable(rx_slip_count))
    else $error("slip count moved without a sync");
  a_rx_slip_load: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (aligner_sync && ctrl_reg.manual_align) |=> rx_slip_count == $past(aligner_slip))
    else $error("slip count not loaded on sync");
  a_tx_slip_range: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    tx_slip_reg <= `SLIP_MAX)
    else $error("transmit slip above nine");
  a_sdi_unbonded: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $past(is_sdi) && $stable(ctrl_reg) |-> !bonded_x4)
    else $error("SDI mode left bonded");
  a_rev_par_entry: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rev_par_lpbk_en |-> $past(detect_loopback && power_state == `PWR_P0 && is_pipe))
    else $error("reverse parallel loopback without P0 request");
  a_serial_not_pipe: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    serial_lpbk_en |-> $past(!is_pipe))
    else $error("serial loopback in PIPE mode");
  a_loop_word_path: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (rpar_reg && rx_take && tx_slip_reg == 5'h00) ##1 rpar_reg
    |=> ser_tx_valid && ser_tx_data == $past(rx_word, 2))
    else $error("looped word not sent to serializer");
  a_pfd_condition: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    phase_freq_detector_fb |-> $past(ctrl_reg.refclk_eq && is_fixed))
    else $error("feedback enabled without equal clocks");
  a_sdi_no_slip: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $past(is_sdi) |-> !aligner_slip_req)
    else $error("slip request passed in SDI mode");
  a_bus_answer: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
endmodule

// ===== src/pcs_lat_defs.svh
// Register offsets, field positions, reset values and encodings of the PCS control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses; included by the package.
`ifndef PCS_LAT_DEFS_SVH
`define PCS_LAT_DEFS_SVH
`define OFS_CTRL 4'h0
`define OFS_TX_SLIP 4'h4
`define OFS_RX_SLIP 4'h8
`define OFS_STATUS 4'hC
`define CTRL_W 12
`define CTRL_RESET 12'h000
`define SLIP_W 5
`define SLIP_MAX 5'h09
`define ST_CFG_ERR 0
`define ST_REV_PAR 1
`define ST_SLIP_REJ 2
`define ST_WIDTH20 3
`define PWR_P0 2'h0
`define LPBK_NONE 2'h0
`define LPBK_SERIAL 2'h1
`define LPBK_REV_SER 2'h2
`define LPBK_REV_PAR 2'h3
`endif

// ===== src/pcs_lat_pkg.sv
// Types shared by the PCS control block and its helpers.
// Assumes the constants header is on the include path.
`include "pcs_lat_defs.svh"
package pcs_lat_pkg;
  typedef enum logic [2:0] {
    MODE_BASIC = 3'h0,
    MODE_FIXED = 3'h1,
    MODE_SDI = 3'h2,
    MODE_PIPE = 3'h3,
    MODE_XAUI = 3'h4
  } mode_t;
  typedef struct packed {
    logic manual_align;
    logic sdi_3g;
    logic [1:0] lpbk_sel;
    logic byte_ser;
    logic refclk_eq;
    logic pfd_fb;
    logic tx_fifo_reg;
    logic bonded;
    mode_t mode;
  } ctrl_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANS = 2'b10
  } bus_state_t;
endpackage

// ===== src/rx_word_buffer.sv
// Two-entry receive buffer between the word aligner and the fabric.
// Assumes the fabric may stall through out_ready; outputs come from flip-flops.
`timescale 1ns/1ps
module rx_word_buffer #(
  parameter int DW = 10
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic [DW-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side.
  output logic [DW-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [DW-1:0] out_data_reg, out_data_next, spare_reg, spare_next;
  logic out_valid_reg, out_valid_next, spare_valid_reg, spare_valid_next;

  // The head word loads straight from the input, so an unstalled word sees one register.
  always_comb begin
    out_data_next = out_data_reg;
    out_valid_next = out_valid_reg;
    spare_next = spare_reg;
    spare_valid_next = spare_valid_reg;
    if (!out_valid_reg || out_ready) begin
      if (spare_valid_reg) begin
        out_data_next = spare_reg;
        out_valid_next = 1'b1;
        spare_valid_next = 1'b0;
      end else begin
        out_data_next = in_data;
        out_valid_next = in_valid;
      end
    end else if (in_valid && !spare_valid_reg) begin
      spare_next = in_data;
      spare_valid_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data_reg <= '0;
      out_valid_reg <= 1'b0;
      spare_reg <= '0;
      spare_valid_reg <= 1'b0;
    end else begin
      out_data_reg <= out_data_next;
      out_valid_reg <= out_valid_next;
      spare_reg <= spare_next;
      spare_valid_reg <= spare_valid_next;
    end
  end

  assign in_ready = !spare_valid_reg;
  assign out_data = out_data_reg;
  assign out_valid = out_valid_reg;

  a_buf_one_cycle: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (in_valid && in_ready && !out_valid) |=> (out_valid && out_data == $past(in_data)))
    else $error("buffer did not present word one cycle later");
endmodule

// ===== src/tx_bit_slip.sv
// Transmit bit slip: delays the serial stream by a whole number of bits.
// Assumes bit 0 is sent first and slip is at most nine bits, even for an 8-bit word.
`timescale 1ns/1ps
module tx_bit_slip #(
  parameter int DW = 10
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Parallel word in and slip amount.
  input wire logic [DW-1:0] in_data,
  input wire logic in_valid,
  input wire logic [4:0] slip,
  // Slipped word out.
  output logic [DW-1:0] out_data,
  output logic out_valid
);
  logic [DW-1:0] prev_reg, prev_next, prev2_reg, prev2_next, out_reg, out_next;
  logic valid_reg, valid_next;
  logic [3*DW-1:0] pair;

  if (DW < 8) begin : g_bad_width
    $error("word width must be at least 8");
  end

  // Two words of history, so a nine-bit slip still fits when the word is only eight bits.
  always_comb begin
    pair = {in_data, prev_reg, prev2_reg};
    prev_next = in_valid ? in_data : prev_reg;
    prev2_next = in_valid ? prev_reg : prev2_reg;
    out_next = out_reg;
    if (in_valid) begin
      out_next = pair[(2 * DW - int'(slip)) +: DW];
    end
    valid_next = in_valid;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
      prev2_reg <= '0;
      out_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      prev2_reg <= prev2_next;
      out_reg <= out_next;
      valid_reg <= valid_next;
    end
  end

  assign out_data = out_reg;
  assign out_valid = valid_reg;

  a_slip_zero_pass: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (in_valid && slip == 5'h00) |=> (out_data == $past(in_data)))
    else $error("zero slip changed the word");
endmodule

// ===== tb/aligner_model.sv
// Behavioural word aligner: streams counting words and reports sync events with a slip.
// Assumes the block takes a word at a rising edge where valid and ready are both high.
`timescale 1ns/1ps
module aligner_model #(
  parameter int DW = 10
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Controls from the bench.
  input wire logic en,
  input wire logic sync_go,
  input wire logic [4:0] slip_val,
  // Aligner outputs towards the block.
  output logic [DW-1:0] rx_word,
  output logic rx_word_valid,
  input wire logic rx_word_ready,
  output logic aligner_sync,
  output logic [4:0] aligner_slip
);
  logic [DW-1:0] cnt;
  logic v;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt = '0;
      rx_word_valid <= 1'b0;
      rx_word <= '1;
      aligner_sync <= 1'b0;
      aligner_slip <= 5'h0;
    end else begin
      if (rx_word_valid && rx_word_ready) begin
        cnt = cnt + 1'b1;
      end
      v = rx_word_valid && !rx_word_ready;
      if (!v) begin
        v = en && ($urandom_range(3) != 0);
      end
      rx_word_valid <= v;
      // An idle line inverts every bit each cycle, so it swings between the inverse of the last word and that word.
      rx_word <= v ? cnt : ~rx_word;
      aligner_sync <= sync_go;
      // The slip keeps moving between syncs to show whether the count holds.
      aligner_slip <= sync_go ? slip_val : aligner_slip + 5'h1;
    end
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the PCS latency, SDI and loopback control block.
// Assumes the aligner model on the receive side; the bench plays fabric and bus master.
`timescale 1ns/1ps
`include "pcs_lat_defs.svh"
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic avs_waitrequest;
  logic [9:0] rx_word, fab_rx_data, ser_tx_data;
  logic [9:0] fab_tx_data = 10'h0;
  logic [9:0] exp_rx = 10'h0;
  logic rx_word_valid, rx_word_ready, aligner_sync, aligner_slip_req, fab_rx_valid, ser_tx_valid;
  logic [4:0] aligner_slip, rx_slip_count;
  logic [4:0] slip_val = 5'h0;
  logic fab_rx_ready = 1'b0;
  logic rx_slip_req = 1'b0;
  logic detect_loopback = 1'b0;
  logic [1:0] power_state = 2'h0;
  logic [6:0] cfg_out;
  logic en = 1'b0;
  logic sync_go = 1'b0;
  logic stall = 1'b0;
  int fail_count = 0;
  int compares = 0;
  logic [11:0] cv[15] = '{12'h061, 12'h069, 12'h021, 12'h00A, 12'h482, 12'h402, 12'h100,
                          12'h103, 12'h204, 12'h200, 12'h303, 12'h303, 12'h303, 12'h300, 12'h068};

  always #4 sys_clk = ~sys_clk;

  pcs_latency_ctrl u_dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .rx_word, .rx_word_valid,
    .rx_word_ready, .aligner_sync, .aligner_slip, .aligner_slip_req, .rx_slip_count,
    .fab_rx_data, .fab_rx_valid, .fab_rx_ready, .fab_tx_data, .fab_tx_valid(1'b1), .rx_slip_req,
    .detect_loopback, .power_state, .ser_tx_data, .ser_tx_valid, .serial_lpbk_en(cfg_out[0]),
    .rev_serial_lpbk_en(cfg_out[1]), .rev_par_lpbk_en(cfg_out[2]),
    .phase_freq_detector_fb(cfg_out[3]), .fb_from_coreclk(cfg_out[4]), .bonded_x4(cfg_out[5]),
    .fabric_width_20(cfg_out[6]));

  aligner_model u_aligner (.sys_clk, .rst_n, .en, .sync_go, .slip_val, .rx_word, .rx_word_valid,
    .rx_word_ready, .aligner_sync, .aligner_slip);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The request is held until an edge that sees waitrequest low; the wait is bounded.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  function automatic logic [9:0] slipf(logic [9:0] cur, logic [9:0] prev, int s);
    logic [19:0] c;
    c = {cur, prev};
    return c[10-s +: 10];
  endfunction

  // Bits [7:0] are the expected pins, [11:8] the expected status nibble.
  function automatic logic [11:0] cfg_exp(logic [11:0] c, logic det, logic [1:0] pw);
    logic [2:0] m;
    logic [1:0] lp;
    logic err;
    m = c[2:0];
    lp = c[9:8];
    cfg_exp[0] = lp == `LPBK_SERIAL && m != pcs_lat_pkg::MODE_PIPE;
    cfg_exp[1] = lp == `LPBK_REV_SER && m != pcs_lat_pkg::MODE_XAUI;
    cfg_exp[2] = lp == `LPBK_REV_PAR && m == pcs_lat_pkg::MODE_PIPE && det && pw == `PWR_P0;
    cfg_exp[3] = c[5] && c[6] && m == pcs_lat_pkg::MODE_FIXED;
    cfg_exp[4] = c[3] && m != pcs_lat_pkg::MODE_SDI;
    cfg_exp[5] = c[3] && m != pcs_lat_pkg::MODE_SDI;
    cfg_exp[6] = c[7] || (m == pcs_lat_pkg::MODE_SDI && c[10]);
    cfg_exp[7] = m != pcs_lat_pkg::MODE_SDI;
    err = (m == pcs_lat_pkg::MODE_SDI && (c[3] || (c[10] && !c[7]))) || (c[5] && !c[6]);
    err = err || (lp == `LPBK_REV_PAR && m != pcs_lat_pkg::MODE_PIPE);
    cfg_exp[11:8] = {cfg_exp[6], 1'b0, cfg_exp[2], err};
  endfunction

  task automatic tx_run(int lat, int s);
    logic [9:0] h[$];
    logic [10:0] ex;
    for (int i = 0; i < 24; i++) begin
      @(negedge sys_clk);
      h.push_back(fab_tx_data);
      if (i > lat) begin
        ex = {1'b1, slipf(h[i-lat], h[i-lat-1], s)};
        chk({ser_tx_valid, ser_tx_data}, ex);
      end
    end
  endtask

  task automatic pulse(input logic [4:0] s);
    @(posedge sys_clk);
    slip_val <= s;
    sync_go <= 1'b1;
    @(posedge sys_clk);
    sync_go <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    fab_tx_data <= 10'($urandom);
    fab_rx_ready <= !stall && ($urandom_range(3) != 0);
  end

  // Every word the fabric takes must be the next in sequence, loopback or not.
  always @(negedge sys_clk) begin
    if (rst_n && fab_rx_valid === 1'b1 && fab_rx_ready === 1'b1) begin
      chk({22'h0, fab_rx_data}, {22'h0, exp_rx});
      exp_rx <= exp_rx + 10'h1;
    end
  end

  initial begin
    #200000;
    fail_count++;
    conclude;
  end

  initial begin
    int s;
    logic [11:0] e;
    void'($urandom(32'h3634));
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({avs_waitrequest, rx_word_ready}, 2'b11);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    en <= 1'b1;
    for (int a = 0; a < 16; a += 2) begin
      bus(1'b0, 4'(a), 32'h0);
      chk(q, 32'h0);
    end
    $display("test reset values done");
    bus(1'b1, `OFS_TX_SLIP, 32'h9);
    bus(1'b0, `OFS_TX_SLIP, 32'h0);
    chk(q, 32'h9);
    bus(1'b1, `OFS_TX_SLIP, 32'hA);
    bus(1'b0, `OFS_TX_SLIP, 32'h0);
    chk(q, 32'h9);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk(q, 32'h4);
    bus(1'b1, `OFS_STATUS, 32'h4);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk(q, 32'h0);
    $display("test slip limits done");
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, `OFS_CTRL, (m == 0) ? 32'h1 : (m == 1) ? 32'h11 : 32'h0);
      for (int k = 0; k < 4; k++) begin
        s = (k == 0) ? 0 : (k == 1) ? 1 : (k == 2) ? 9 : $urandom_range(9);
        bus(1'b1, `OFS_TX_SLIP, 32'(s));
        tx_run((m == 0) ? 1 : 2, s);
      end
    end
    $display("test transmit latency and slip done");
    bus(1'b1, `OFS_CTRL, 32'h801);
    for (int k = 0; k < 4; k++) begin
      s = (k == 0) ? 1 : $urandom_range(31);
      pulse(5'(s));
      chk(rx_slip_count, 32'(s));
      bus(1'b0, `OFS_RX_SLIP, 32'h0);
      chk(q, 32'(s));
      if (s <= 9) bus(1'b1, `OFS_TX_SLIP, 32'(s));
    end
    bus(1'b1, `OFS_CTRL, 32'h1);
    pulse(5'(s ^ 1));
    chk(rx_slip_count, 32'(s));
    $display("test receive slip count done");
    stall <= 1'b1;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({rx_word_ready, fab_rx_valid}, 2'b01);
    @(posedge sys_clk);
    stall <= 1'b0;
    en <= 1'b0;
    repeat (30) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(fab_rx_valid, 1'b0);
    en <= 1'b1;
    $display("test receive buffer done");
    rx_slip_req <= 1'b1;
    // Zero slip lets the looped receive words be checked bit for bit at the serializer.
    bus(1'b1, `OFS_TX_SLIP, 32'h0);
    for (int i = 0; i < 15; i++) begin
      bus(1'b1, `OFS_CTRL, {20'h0, cv[i]});
      detect_loopback <= i inside {10, 11, 13};
      power_state <= (i == 11) ? 2'h1 : 2'h0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      e = cfg_exp(cv[i], detect_loopback, power_state);
      chk({aligner_slip_req, cfg_out}, e[7:0]);
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(q, {28'h0, e[11:8]});
    end
    $display("test configuration and loopback done");
    conclude;
  end
endmodule
